// ### core/cam_runtime_override_config.sv
// Cam counter with runtime configuration override and output merging
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Override enable set takes clock, marker, merge and input setup from override bits.
// RULE2: After reset the stored configuration applies until override is enabled.
// RULE3: Marker polarity bit 0 means active high, 1 means active low marker.
// RULE4: Marker phase bit 0 qualifies during B high, 1 during B low.
// RULE5: Clock source high counts up from the internal clock, ignoring encoder direction.
// RULE6: Clock source low counts from decoded quadrature A and B.
// RULE7: Rate bits 00,01,10,11 pick 1 MHz, 100 kHz, 10 kHz, 1 kHz.
// RULE8: Merge bit 1 removes cam signal from own pin and merges it onward.
// RULE9: Destinations: 1 to 2, 2 to 4, 3 to 4, 4 to 8, 5 to 6, 6 to 8, 7 to 8.
// RULE10: Merges chain; a signal appears at its chain's final destination pin.
// RULE11: A merged-away pin is driven by the host output bit of the same number.
// RULE12: Every merge bit combination is valid, up to eight cams on one pin.
// RULE13: Cam signal 8 always drives pin 8 and has no merge bit.
// RULE14: Threshold and filter follow override bits only while override is enabled.
// RULE15: Threshold bits 00,01,10,11 give 12 V, 6 V, 1.4 V, 0 V AC codes.
// RULE16: Filter bits 00 high, 01 medium, 1x low frequency filter.
// RULE17: Host overriding any bit must drive all override bits explicitly.
// RULE18: Quadrature counts on every A and B edge; rising A with B low counts up.
// RULE19: Each cam has ON and OFF counts; its signal switches at those counts.
// RULE20: A pin carrying merged cam signals is the OR of those signals.
module cam_runtime_override_config #(
  parameter int unsigned COUNT_WIDTH = cam_cfg_pkg::COUNT_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cam_cfg_pkg::enc_pins_s enc_pins,
  input wire logic marker_disable,
  input wire cam_cfg_pkg::cam_cfg_s stored_cfg,
  input wire logic override_enable,
  input wire cam_cfg_pkg::cam_cfg_s override_cfg,
  input wire logic [cam_cfg_pkg::MERGE_COUNT-1:0] general_output_bits,
  input wire logic [COUNT_WIDTH-1:0] counts_per_rev,
  input wire logic [cam_cfg_pkg::CAM_COUNT*COUNT_WIDTH-1:0] on_counts,
  input wire logic [cam_cfg_pkg::CAM_COUNT*COUNT_WIDTH-1:0] off_counts,
  output logic [cam_cfg_pkg::CAM_COUNT-1:0] out_pins,
  output logic [COUNT_WIDTH-1:0] position,
  output logic [1:0] threshold_code,
  output cam_cfg_pkg::filter_e filter_code,
  output logic marker_seen
);

  localparam int unsigned NC = cam_cfg_pkg::CAM_COUNT;
  localparam int unsigned NM = cam_cfg_pkg::MERGE_COUNT;

  // **********************************************************
  // State
  // **********************************************************
  typedef struct packed {
    logic [2:0] a_sync;
    logic [2:0] b_sync;
    logic [1:0] m_sync;
    logic [1:0] md_sync;
    logic [cam_cfg_pkg::DIV_WIDTH-1:0] div_cnt;
    logic [COUNT_WIDTH-1:0] count;
    logic marker_prev;
    logic [NC-1:0] cam_sig;
    logic [NC-1:0] pins;
    logic [1:0] thresh;
    cam_cfg_pkg::filter_e filt;
    logic marker_seen;
  } state_s;

  state_s cur;
  state_s next_cur;

  // **********************************************************
  // Helpers
  // **********************************************************
  // Divider terminal count for a rate code
  function automatic logic [cam_cfg_pkg::DIV_WIDTH-1:0] div_limit(input logic [1:0] sel);
    case (sel)
      cam_cfg_pkg::RATE_SEL_1M: div_limit = cam_cfg_pkg::DIV_WIDTH'(cam_cfg_pkg::DIV_1M - 1);
      cam_cfg_pkg::RATE_SEL_100K: div_limit = cam_cfg_pkg::DIV_WIDTH'(cam_cfg_pkg::DIV_100K - 1);
      cam_cfg_pkg::RATE_SEL_10K: div_limit = cam_cfg_pkg::DIV_WIDTH'(cam_cfg_pkg::DIV_10K - 1);
      default: div_limit = cam_cfg_pkg::DIV_WIDTH'(cam_cfg_pkg::DIV_1K - 1);
    endcase
  endfunction

  // Filter decode, low filter whenever the upper bit is set
  function automatic cam_cfg_pkg::filter_e filt_decode(input logic hi, input logic lo);
    if (hi) begin
      filt_decode = cam_cfg_pkg::filt_low; // [RULE16]
    end else if (lo) begin
      filt_decode = cam_cfg_pkg::filt_medium;
    end else begin
      filt_decode = cam_cfg_pkg::filt_high;
    end
  endfunction

  // **********************************************************
  // Configuration select
  // **********************************************************
  cam_cfg_pkg::cam_cfg_s act;
  // Stored set from reset until the host raises override
  assign act = override_enable ? override_cfg : stored_cfg; // [RULE1] [RULE2] [RULE14]

  // **********************************************************
  // Cam windows and merge routing
  // **********************************************************
  logic [NC-1:0] cam_next;
  logic [NC-1:0] final_dest [NC];
  logic [NC-1:0] routed;

  // Window compare per cam; wrapped windows allowed when ON exceeds OFF
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_cam
      logic [COUNT_WIDTH-1:0] on_c;
      logic [COUNT_WIDTH-1:0] off_c;
      assign on_c = on_counts[gi*COUNT_WIDTH +: COUNT_WIDTH];
      assign off_c = off_counts[gi*COUNT_WIDTH +: COUNT_WIDTH];
      assign cam_next[gi] = (on_c <= off_c) ? (cur.count >= on_c && cur.count < off_c)
                                            : (cur.count >= on_c || cur.count < off_c); // [RULE19]
    end
  endgenerate

  // Follow each cam down its merge chain; destinations only rise, so NC steps suffice
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      logic [2:0] at;
      at = 3'(c);
      for (int s = 0; s < NC; s++) begin
        if (at < 3'(NM) && act.merge_cam[at]) begin // [RULE10] [RULE12]
          at = cam_cfg_pkg::MERGE_DEST[at]; // [RULE9]
        end
      end
      final_dest[c] = NC'(1) << at;
    end
  end

  // Each pin is the OR of every cam whose chain ends on it
  always_comb begin
    routed = '0;
    for (int c = 0; c < NC; c++) begin
      if (cur.cam_sig[c]) begin
        routed = routed | final_dest[c]; // [RULE20]
      end
    end
  end

  // **********************************************************
  // Next state
  // **********************************************************
  always_comb begin
    logic a_now;
    logic b_now;
    logic a_edge;
    logic b_edge;
    logic up;
    logic step;
    logic tick;
    logic mk_active;
    logic mk_rise;
    cam_cfg_pkg::cnt_mode_e mode;
    a_now = 1'b0;
    b_now = 1'b0;
    a_edge = 1'b0;
    b_edge = 1'b0;
    up = 1'b0;
    step = 1'b0;
    tick = 1'b0;
    mk_active = 1'b0;
    mk_rise = 1'b0;
    next_cur = cur;

    // Two flops before any logic looks at a pin
    next_cur.a_sync = {cur.a_sync[1:0], enc_pins.phase_a};
    next_cur.b_sync = {cur.b_sync[1:0], enc_pins.phase_b};
    next_cur.m_sync = {cur.m_sync[0], enc_pins.marker};
    next_cur.md_sync = {cur.md_sync[0], marker_disable};

    a_now = cur.a_sync[1];
    b_now = cur.b_sync[1];
    a_edge = cur.a_sync[1] ^ cur.a_sync[2];
    b_edge = cur.b_sync[1] ^ cur.b_sync[2];

    mode = act.count_clock_source ? cam_cfg_pkg::cnt_internal : cam_cfg_pkg::cnt_quad;

    // Rate divider runs all the time so a switch takes effect cleanly
    if (cur.div_cnt >= div_limit({act.int_clock_rate_hi, act.int_clock_rate_lo})) begin // [RULE7]
      next_cur.div_cnt = '0;
      tick = 1'b1;
    end else begin
      next_cur.div_cnt = cur.div_cnt + 1'b1;
    end

    case (mode)
      cam_cfg_pkg::cnt_internal: begin
        step = tick; // [RULE5]
        up = 1'b1; // [RULE5]
      end
      cam_cfg_pkg::cnt_quad: begin
        // 4X decode: direction from the edge and the other phase
        step = a_edge | b_edge; // [RULE6] [RULE18]
        up = a_edge ? (a_now ^ b_now) : ~(a_now ^ b_now); // [RULE18]
      end
      default: begin
        step = 1'b0;
        up = 1'b1;
      end
    endcase

    // Marker qualified by polarity and B phase; edge re-homes the count in quadrature mode only
    mk_active = (cur.m_sync[1] ^ act.marker_polarity_select) // [RULE3]
                & (b_now ^ act.marker_phase_select) // [RULE4]
                & ~cur.md_sync[1];
    mk_rise = mk_active & ~cur.marker_prev;
    next_cur.marker_prev = mk_active;

    if (mk_rise && mode == cam_cfg_pkg::cnt_quad) begin
      next_cur.count = '0;
      next_cur.marker_seen = 1'b1;
    end else if (step) begin
      if (up) begin
        next_cur.count = (cur.count + 1'b1 >= counts_per_rev) ? '0 : cur.count + 1'b1;
      end else begin
        next_cur.count = (cur.count == '0) ? counts_per_rev - 1'b1 : cur.count - 1'b1;
      end
    end

    next_cur.cam_sig = cam_next;

    // Cam 8 always routed; merged-away pins fall to host bits
    for (int p = 0; p < NC; p++) begin
      if (p < NM && act.merge_cam[p]) begin
        next_cur.pins[p] = general_output_bits[p]; // [RULE8] [RULE11]
      end else begin
        next_cur.pins[p] = routed[p]; // [RULE13]
      end
    end

    next_cur.thresh = {act.threshold_sel_hi, act.threshold_sel_lo}; // [RULE15]
    next_cur.filt = filt_decode(act.filter_sel_hi, act.filter_sel_lo);
  end

  // **********************************************************
  // Register
  // **********************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur <= '0;
      cur.filt <= cam_cfg_pkg::filt_high;
    end else begin
      cur <= next_cur;
    end
  end

  assign out_pins = cur.pins;
  assign position = cur.count;
  assign threshold_code = cur.thresh;
  assign filter_code = cur.filt;
  assign marker_seen = cur.marker_seen;

endmodule // cam_runtime_override_config

`default_nettype wire

// ### core/cam_cfg_pkg.sv
// Package: constants and carrier types for the cam runtime override block
package cam_cfg_pkg;

  localparam int unsigned CAM_COUNT = 8;
  localparam int unsigned MERGE_COUNT = 7;
  localparam int unsigned COUNT_WIDTH = 24;

  // Time base
  localparam int unsigned REF_CLK_HZ = 40_000_000;
  localparam int unsigned RATE_1M_HZ = 1_000_000;
  localparam int unsigned RATE_100K_HZ = 100_000;
  localparam int unsigned RATE_10K_HZ = 10_000;
  localparam int unsigned RATE_1K_HZ = 1_000;
  localparam int unsigned DIV_1M = REF_CLK_HZ / RATE_1M_HZ;
  localparam int unsigned DIV_100K = REF_CLK_HZ / RATE_100K_HZ;
  localparam int unsigned DIV_10K = REF_CLK_HZ / RATE_10K_HZ;
  localparam int unsigned DIV_1K = REF_CLK_HZ / RATE_1K_HZ;
  localparam int unsigned DIV_WIDTH = 16;

  // Internal clock rate codes {hi, lo}
  localparam logic [1:0] RATE_SEL_1M = 2'h0;
  localparam logic [1:0] RATE_SEL_100K = 2'h1;
  localparam logic [1:0] RATE_SEL_10K = 2'h2;
  localparam logic [1:0] RATE_SEL_1K = 2'h3;

  // Threshold codes {hi, lo}
  localparam logic [1:0] THRESH_12V = 2'h0;
  localparam logic [1:0] THRESH_6V = 2'h1;
  localparam logic [1:0] THRESH_1V4 = 2'h2;
  localparam logic [1:0] THRESH_AC = 2'h3;

  typedef enum logic [1:0] {
    filt_high,
    filt_medium,
    filt_low
  } filter_e;

  // Merge destinations, index is cam number minus one
  localparam logic [2:0] MERGE_DEST [MERGE_COUNT] = '{3'h1, 3'h3, 3'h3, 3'h7, 3'h5, 3'h7, 3'h7};

  // One full configuration set: stored or runtime override
  typedef struct packed {
    logic marker_polarity_select;
    logic marker_phase_select;
    logic count_clock_source;
    logic int_clock_rate_hi;
    logic int_clock_rate_lo;
    logic [MERGE_COUNT-1:0] merge_cam;
    logic threshold_sel_hi;
    logic threshold_sel_lo;
    logic filter_sel_hi;
    logic filter_sel_lo;
  } cam_cfg_s;

  // Encoder pin group
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic marker;
  } enc_pins_s;

  typedef enum logic [1:0] {
    cnt_quad,
    cnt_internal
  } cnt_mode_e;

endpackage

// ### testbench/cam_override_assertions.sv
// Port checker for the cam runtime override block
`timescale 1ns/1ps
`default_nettype none

// ****
// Checker
// ****
module cam_override_assertions #(
  parameter int unsigned COUNT_WIDTH = 24
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cam_cfg_pkg::cam_cfg_s stored_cfg,
  input wire logic override_enable,
  input wire cam_cfg_pkg::cam_cfg_s override_cfg,
  input wire logic [6:0] general_output_bits,
  input wire logic [COUNT_WIDTH-1:0] counts_per_rev,
  input wire logic [7:0] out_pins,
  input wire logic [COUNT_WIDTH-1:0] position,
  input wire logic [1:0] threshold_code,
  input wire cam_cfg_pkg::filter_e filter_code,
  input wire logic marker_seen
);
  cam_cfg_pkg::cam_cfg_s cfg;
  cam_cfg_pkg::filter_e filt;
  logic [1:0] thr;
  logic [6:0] mrg;
  logic [COUNT_WIDTH-1:0] pos_q, diff;
  logic src_int, rate1m;

  // Active selection as the host sees it
  always_comb begin
    cfg = override_enable ? override_cfg : stored_cfg;
    thr = {cfg.threshold_sel_hi, cfg.threshold_sel_lo};
    filt = cfg.filter_sel_hi ? cam_cfg_pkg::filt_low
      : (cfg.filter_sel_lo ? cam_cfg_pkg::filt_medium : cam_cfg_pkg::filt_high);
    mrg = cfg.merge_cam;
    src_int = cfg.count_clock_source;
    rate1m = {cfg.int_clock_rate_hi, cfg.int_clock_rate_lo} == 2'h0;
    diff = position - pos_q;
  end

  // Last position, for per-cycle step size
  always_ff @(posedge ref_clk) begin
    pos_q <= position;
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Settled internal clocking; five cycles lets mode changes land
  sequence src_steady;
    src_int [*5];
  endsequence
  sequence int_steady;
    (src_int && rate1m) [*5];
  endsequence

  thr_select_a: assert property (!$past(rst) |-> threshold_code == $past(thr))
    else $error("threshold code wrong");
  filt_select_a: assert property (!$past(rst) |-> filter_code == $past(filt))
    else $error("filter code wrong");
  gp_pin_a: assert property (
    !$past(rst) |-> ((out_pins[6:0] ^ $past(general_output_bits)) & $past(mrg)) == 7'h0)
    else $error("merged-away pin not general output");
  reset_clear_a: assert property (
    $fell(rst) |-> position == '0 && out_pins == '0 && !marker_seen)
    else $error("outputs not cleared by reset");
  marker_sticky_a: assert property (marker_seen |=> marker_seen)
    else $error("marker flag dropped");
  pos_step_a: assert property (diff != '0 |-> diff == COUNT_WIDTH'(1)
    || diff == '1 || position == '0 || position == counts_per_rev - 1)
    else $error("position jumped");
  internal_up_a: assert property (
    src_steady ##0 diff != '0 |-> diff == COUNT_WIDTH'(1) || position == '0)
    else $error("internal mode not counting up");
  tick_gap_a: assert property (
    int_steady ##0 diff == COUNT_WIDTH'(1) |=> (diff == '0) [*8])
    else $error("internal ticks too close");
endmodule // cam_override_assertions

bind cam_runtime_override_config cam_override_assertions #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (
  .ref_clk, .rst, .stored_cfg, .override_enable, .override_cfg, .general_output_bits,
  .counts_per_rev, .out_pins, .position, .threshold_code, .filter_code, .marker_seen
);
`default_nettype wire

// ### testbench/enc_model.sv
// Partner model: quadrature encoder with marker
`timescale 1ns/1ps
`default_nettype none

// ****
// Encoder
// ****
module enc_model (
  input wire logic ref_clk,
  output var cam_cfg_pkg::enc_pins_s pins
);
  logic [1:0] idx = 2'h0;

  // Idle: phases low, marker high (inactive for an active-low marker)
  initial begin
    pins = 3'b001;
  end

  // One quarter cycle, spaced well past the input synchroniser
  task automatic step(input logic up);
    repeat (4) @(posedge ref_clk);
    #2;
    idx = up ? idx + 2'h1 : idx - 2'h1;
    pins.phase_a = idx[0] ^ idx[1];
    pins.phase_b = idx[1];
  endtask

  // Low-going marker pulse, kept inside one B level
  task automatic mark();
    repeat (2) @(posedge ref_clk);
    #2;
    pins.marker = 1'b0;
    repeat (4) @(posedge ref_clk);
    #2;
    pins.marker = 1'b1;
  endtask
endmodule // enc_model
`default_nettype wire

// ### testbench/cam_runtime_override_config_tb.sv
// Self-checking bench for the cam runtime override block
`timescale 1ns/1ps
`default_nettype none

// ****
// Bench top
// ****
module cam_runtime_override_config_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic override_enable = 1'b0;
  cam_cfg_pkg::cam_cfg_s stored_cfg = '0;
  cam_cfg_pkg::cam_cfg_s override_cfg = '0;
  wire cam_cfg_pkg::enc_pins_s enc_pins;
  logic [6:0] general_output_bits = '0;
  logic [191:0] off_counts = '0;
  logic [191:0] on_counts = '0;
  logic marker_disable = 1'b0;
  logic [7:0] out_pins, act;
  logic [23:0] position;
  logic [1:0] threshold_code, k;
  cam_cfg_pkg::filter_e filter_code;
  logic marker_seen;
  logic [6:0] mcase [6] = '{7'h00, 7'h76, 7'h55, 7'h7F, 7'h09, 7'h21};
  int fail_count = 0;
  int compares = 0;

  cam_runtime_override_config u_cam_runtime_override_config (
    .ref_clk, .rst, .enc_pins, .marker_disable, .stored_cfg, .override_enable,
    .override_cfg, .general_output_bits, .counts_per_rev(24'h00_1000), .on_counts,
    .off_counts, .out_pins, .position, .threshold_code, .filter_code, .marker_seen
  );
  enc_model u_enc_model (.ref_clk, .pins(enc_pins));

  // 40 MHz reference
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Expected pins: follow each chain to its end, OR in, then general bits
  function automatic logic [7:0] route(input logic [6:0] m, input logic [7:0] a,
                                       input logic [6:0] g);
    logic [2:0] dst [7] = '{3'h1, 3'h3, 3'h3, 3'h7, 3'h5, 3'h7, 3'h7};
    int d;
    route = '0;
    for (int i = 0; i < 8; i++) begin
      d = i;
      while (d < 7 && m[d]) d = dst[d];
      route[d] |= a[i];
    end
    for (int p = 0; p < 7; p++) begin
      if (m[p]) route[p] = g[p];
    end
  endfunction

  // First change only resyncs; the second gap is the true period
  task automatic rate_check(input logic [1:0] r, input int div);
    logic [23:0] p;
    int n;
    {override_cfg.int_clock_rate_hi, override_cfg.int_clock_rate_lo} = r;
    for (int s = 0; s < 2; s++) begin
      p = position;
      n = 0;
      while (position === p && n < 2 * div + 8) begin
        tick(1);
        n++;
      end
    end
    check("tick_gap", 24'(div), 24'(n));
    check("position", p + 24'h1, position);
  endtask

  // Main sequence
  initial begin
    tick(4);
    rst = 1'b0;
    for (int c = 0; c < 8; c++) begin
      {stored_cfg.threshold_sel_hi, stored_cfg.threshold_sel_lo} = c[1:0];
      {stored_cfg.filter_sel_hi, stored_cfg.filter_sel_lo} = c[1:0];
      {override_cfg.threshold_sel_hi, override_cfg.threshold_sel_lo} = ~c[1:0];
      {override_cfg.filter_sel_hi, override_cfg.filter_sel_lo} = ~c[1:0];
      override_enable = c[2];
      k = c[2] ? ~c[1:0] : c[1:0];
      tick(2);
      check("threshold", {22'h0, k}, threshold_code);
      check("filter", k[1] ? 24'h2 : {22'h0, k}, filter_code);
    end
    for (int i = 0; i < 6; i++) begin
      act = 8'h96 ^ (8'h11 << i);
      for (int n = 0; n < 8; n++) begin
        off_counts[n*24 +: 24] = {23'h0, act[n]};
      end
      general_output_bits = 7'h2B ^ 7'(i);
      override_enable = i[0];
      override_cfg.merge_cam = i[0] ? mcase[i] : ~mcase[i];
      stored_cfg.merge_cam = i[0] ? ~mcase[i] : mcase[i];
      tick(4);
      check("out_pins", {16'h0, route(mcase[i], act, general_output_bits)}, out_pins);
    end
    stored_cfg = '0;
    stored_cfg.marker_polarity_select = 1'b1;
    override_enable = 1'b0;
    repeat (6) u_enc_model.step(1'b1);
    repeat (2) u_enc_model.step(1'b0);
    u_enc_model.mark();
    tick(4);
    check("position", 24'h4, position);
    check("marker_seen", 24'h0, marker_seen);
    repeat (2) u_enc_model.step(1'b1);
    u_enc_model.mark();
    tick(4);
    check("marker_seen", 24'h1, marker_seen);
    check("position", 24'h0, position);
    // Masked marker must leave the count alone
    marker_disable = 1'b1;
    repeat (4) u_enc_model.step(1'b1);
    u_enc_model.mark();
    tick(4);
    check("masked_position", 24'h4, position);
    marker_disable = 1'b0;
    override_cfg = '0;
    override_cfg.count_clock_source = 1'b1;
    override_enable = 1'b1;
    for (int r = 0; r < 4; r++) begin
      rate_check(r[1:0], 40 * 10 ** r);
    end
    final_report();
  end

  // Watchdog
  initial begin
    repeat (95000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end
endmodule // cam_runtime_override_config_tb
`default_nettype wire
